// ---- hw/cmx_cfg.svh ----
// Purpose: Constants of the command message exchange, both ends.
// Assumes: One command instance, byte wide management registers.
// Notes: Offsets are byte addresses within the managed memory map.
`ifndef CMX_CFG_SVH
`define CMX_CFG_SVH
`define CMX_ADDR_FLAGS 8'h08
`define CMX_ADDR_MASK 8'h1f
`define CMX_ADDR_STAT1 8'h25
`define CMX_ADDR_STAT2 8'h26
`define CMX_ADDR_PAGE 8'h7f
`define CMX_ADDR_HDR 8'h80
`define CMX_ADDR_TRIG 8'h81
`define CMX_ADDR_RPL_LEN 8'h86
`define CMX_ADDR_LPL 8'h88
`define CMX_ADDR_ADV0 8'ha3
`define CMX_ADDR_ADV3 8'ha6
`define CMX_PAGE_ADV 8'h01
`define CMX_PAGE_MSG 8'h9f
`define CMX_PAGE_EPL0 8'ha0
`define CMX_PAGE_EPL15 8'haf
`define CMX_FLAG_BIT 3
`define CMX_FLAG_INST1 8'h40
`define CMX_FLAG_USED 8'hc0
`define CMX_RST_MASK 8'h00
`define CMX_RST_PAGE 8'h00
`define CMX_ST_IDLE 8'h00
`define CMX_ST_BUSY 8'h81
`define CMX_ST_OK 8'h01
`define CMX_ST_FAIL 8'h42
`define CMX_ST_ABORTED 8'h45
`define CMX_CMD_ABORT 16'h0004
`define CMX_CMD_LIMIT 16'h0100
`define CMX_ADV_FG 8'h40
`define CMX_ADV_BG 8'h60
`define CMX_ADV_EPL 8'h0f
`define CMX_ADV_STOP 8'h01
`define CMX_EXEC_CYCLES 16
`define CMX_APB_CTRL 12'h000
`define CMX_APB_ADDR 12'h004
`define CMX_APB_WDATA 12'h008
`define CMX_APB_STAT 12'h00c
`endif

// ---- hw/cmx_host.sv ----
// Purpose: Host end, running single link accesses ordered over APB.
// Assumes: Software polls status and sends only abort while busy.
// Notes: A refused access is reported, not retried; software retries.
`timescale 1ns/1ns
`include "cmx_cfg.svh"
module cmx_host import cmx_pkg::*; (
  input wire logic mclk, // Clock.
  input wire logic rstn, // Asynchronous reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB access phase.
  input wire logic pwrite, // APB write.
  input wire logic [11:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic pready, // APB ready.
  output logic [31:0] prdata, // APB read data.
  output logic pslverr, // APB error, always low.
  cmx_link_if.host lk // Link toward the module.
);
  cmx_host_t s;
  cmx_host_t next_s;
  logic setup;
  logic go;

  // Decode on the setup cycle so the answer is ready in the access phase.
  always_comb begin
    next_s = s;
    next_s.req = 1'b0;
    setup = psel && !penable;
    go = setup && pwrite && paddr == `CMX_APB_CTRL && pwdata[0];
    if (setup && pwrite && s.state == CMX_H_IDLE) begin
      if (paddr == `CMX_APB_ADDR) begin
        next_s.addr = pwdata[7:0];
      end else if (paddr == `CMX_APB_WDATA) begin
        next_s.wdata = pwdata[7:0];
      end
    end
    if (setup && !pwrite) begin
      // Polling status is how software follows background work.
      unique case (paddr)
        `CMX_APB_ADDR: next_s.prdata = {24'h000000, s.addr};
        `CMX_APB_WDATA: next_s.prdata = {24'h000000, s.wdata};
        `CMX_APB_STAT: next_s.prdata = {16'h0000, s.rdata, 4'h0, !lk.intr_n, s.nacked,
          s.done, s.state != CMX_H_IDLE};
        default: next_s.prdata = 32'h00000000;
      endcase
    end
    unique case (s.state)
      CMX_H_IDLE: begin
        // One access in flight; a go while busy is ignored.
        if (go) begin
          next_s.wr = pwdata[1];
          next_s.stop = pwdata[2];
          next_s.req = 1'b1;
          next_s.done = 1'b0;
          next_s.nacked = 1'b0;
          next_s.state = CMX_H_REQ;
        end
      end
      CMX_H_REQ: begin
        next_s.state = CMX_H_WAIT;
      end
      CMX_H_WAIT: begin
        // No timeout here: a go is ignored while waiting, so a silent module leaves the host waiting until reset.
        if (lk.ack || lk.nack) begin
          next_s.done = 1'b1;
          next_s.nacked = lk.nack;
          if (lk.ack && !s.wr) begin
            next_s.rdata = lk.rdata;
          end
          next_s.state = CMX_H_IDLE;
        end
      end
      default: begin
        next_s.state = CMX_H_IDLE;
      end
    endcase
  end

  // One register holds the whole host state.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
      s.state <= CMX_H_IDLE;
    end else begin
      s <= next_s;
      s.pready <= 1'b1;
    end
  end

  assign pready = s.pready;
  assign prdata = s.prdata;
  assign pslverr = 1'b0;
  assign lk.req = s.req;
  assign lk.wr = s.wr;
  assign lk.stop = s.stop;
  assign lk.addr = s.addr;
  assign lk.wdata = s.wdata;
endmodule

// ---- hw/cmx_link_if.sv ----
// Purpose: Register access link between host and module.
// Assumes: Both ends run on the same mclk.
// Notes: One request pulse is answered by one ack or nack pulse.
`timescale 1ns/1ns
interface cmx_link_if;
  logic req; // Request pulse.
  logic wr; // Write when high.
  logic stop; // Last byte of a write burst.
  logic [7:0] addr; // Byte address.
  logic [7:0] wdata; // Write data.
  logic ack; // Access served.
  logic nack; // Access refused.
  logic [7:0] rdata; // Read data, valid with ack.
  logic intr_n; // Interrupt request, active low.

  modport host (output req, wr, stop, addr, wdata, input ack, nack, rdata, intr_n);
  modport module_end (input req, wr, stop, addr, wdata, output ack, nack, rdata, intr_n);
endinterface

// ---- hw/cmx_module.sv ----
// Purpose: Module end of the command message exchange.
// Assumes: Host keeps to one exchange at a time, abort excepted.
// Notes: Command execution is a timed stand-in for firmware work.
//
// The APB slave port was decided locally.
`timescale 1ns/1ns
`include "cmx_cfg.svh"
module cmx_module import cmx_pkg::*; #(
  parameter bit FOREGROUND = 1'b0,
  parameter bit TRIG_ON_STOP = 1'b0,
  parameter bit EPL_SUPPORT = 1'b1,
  parameter int EXEC_CYCLES = `CMX_EXEC_CYCLES
) (
  input wire logic mclk, // Clock.
  input wire logic rstn, // Asynchronous reset, active low.
  cmx_link_if.module_end lk, // Link toward the host.
  output logic busy // Command executing.
);
  cmx_dev_t s;
  cmx_dev_t next_s;
  logic ram_we;
  logic [11:0] ram_addr;
  logic [7:0] ram_rdata;
  logic [7:0] clr;
  logic [7:0] set;
  logic trig;
  logic [15:0] cid;
  logic in_lpl;
  logic in_epl;

  // Body storage shared by command parameters and reply data.
  cmx_ram #(.AW(12)) u_ram (
    .mclk(mclk),
    .we(ram_we),
    .addr(ram_addr),
    .wdata(lk.wdata),
    .rdata(ram_rdata)
  );

  // Local area sits above the sixteen extended pages in one array.
  always_comb begin
    in_lpl = s.page == `CMX_PAGE_MSG && lk.addr >= `CMX_ADDR_LPL;
    in_epl = EPL_SUPPORT && s.page >= `CMX_PAGE_EPL0 && s.page <= `CMX_PAGE_EPL15 &&
      lk.addr[7];
    if (in_lpl) begin
      ram_addr = {5'h10, lk.addr[6:0]};
    end else begin
      ram_addr = {1'b0, s.page[3:0], lk.addr[6:0]};
    end
  end

  // Access handling, command engine and flag update.
  always_comb begin
    next_s = s;
    next_s.ack = 1'b0;
    next_s.nack = 1'b0;
    ram_we = 1'b0;
    clr = 8'h00;
    set = 8'h00;
    trig = 1'b0;
    if (lk.req) begin
      if (FOREGROUND && s.state != CMX_IDLE) begin
        next_s.nack = 1'b1;
      end else begin
        next_s.ack = 1'b1;
        if (lk.wr) begin
          if (lk.addr == `CMX_ADDR_PAGE) begin
            next_s.page = lk.wdata;
          end else if (lk.addr == `CMX_ADDR_MASK) begin
            next_s.mask = lk.wdata;
          end else if (s.page == `CMX_PAGE_MSG && lk.addr[7] && !in_lpl) begin
            next_s.hdr[lk.addr[2:0]] = lk.wdata;
          end else if (in_lpl || in_epl) begin
            ram_we = 1'b1;
          end
          // A burst that ends with stop fires if it touched the trigger byte.
          if (s.page == `CMX_PAGE_MSG && lk.addr == `CMX_ADDR_TRIG) begin
            next_s.burst_hit = 1'b1;
          end
          if (TRIG_ON_STOP) begin
            trig = lk.stop && next_s.burst_hit;
          end else begin
            trig = s.page == `CMX_PAGE_MSG && lk.addr == `CMX_ADDR_TRIG;
          end
          if (lk.stop) begin
            next_s.burst_hit = 1'b0;
          end
        end else begin
          next_s.rdata = 8'h00;
          if (lk.addr == `CMX_ADDR_FLAGS) begin
            next_s.rdata = s.flags;
            clr = s.flags;
          end else if (lk.addr == `CMX_ADDR_MASK) begin
            next_s.rdata = s.mask;
          end else if (lk.addr == `CMX_ADDR_STAT1) begin
            next_s.rdata = s.status;
          end else if (lk.addr == `CMX_ADDR_PAGE) begin
            next_s.rdata = s.page;
          end else if (s.page == `CMX_PAGE_ADV && lk.addr == `CMX_ADDR_ADV0) begin
            next_s.rdata = FOREGROUND ? `CMX_ADV_FG : `CMX_ADV_BG;
          end else if (s.page == `CMX_PAGE_ADV && lk.addr == `CMX_ADDR_ADV0 + 8'h01) begin
            next_s.rdata = EPL_SUPPORT ? `CMX_ADV_EPL : 8'h00;
          end else if (s.page == `CMX_PAGE_ADV && lk.addr == `CMX_ADDR_ADV3) begin
            next_s.rdata = TRIG_ON_STOP ? `CMX_ADV_STOP : 8'h00;
          end else if (s.page == `CMX_PAGE_MSG && lk.addr[7] && !in_lpl) begin
            next_s.rdata = s.hdr[lk.addr[2:0]];
          end else if (in_lpl || in_epl) begin
            next_s.rdata = ram_rdata;
          end
        end
      end
    end
    cid = {next_s.hdr[0], next_s.hdr[1]};
    // Commands are never queued; a trigger while busy is dropped unless it aborts during CMX_EXEC.
    unique case (s.state)
      CMX_IDLE: begin
        if (trig && cid == `CMX_CMD_ABORT) begin
          next_s.status = `CMX_ST_OK;
          next_s.state = CMX_POST;
        end else if (trig) begin
          next_s.status = `CMX_ST_BUSY;
          next_s.cnt = 16'h0000;
          next_s.state = CMX_EXEC;
        end
      end
      CMX_EXEC: begin
        if (trig && cid == `CMX_CMD_ABORT) begin
          next_s.status = `CMX_ST_ABORTED;
          next_s.state = CMX_POST;
        end else if (s.cnt == 16'(EXEC_CYCLES - 1)) begin
          // Only the reply fields of the header are written back.
          next_s.status = (cid < `CMX_CMD_LIMIT) ? `CMX_ST_OK : `CMX_ST_FAIL;
          next_s.hdr[3'(`CMX_ADDR_RPL_LEN - `CMX_ADDR_HDR)] = 8'h00;
          next_s.hdr[7] = 8'h00;
          next_s.state = CMX_POST;
        end else begin
          next_s.cnt = s.cnt + 16'h0001;
        end
      end
      CMX_POST: begin
        // Status was written last cycle, so the flag follows it.
        set = `CMX_FLAG_INST1;
        next_s.state = CMX_IDLE;
      end
      default: begin
        next_s.state = CMX_IDLE;
      end
    endcase
    // A completion in the cycle of the clearing read still wins.
    next_s.flags = (s.flags & ~clr) | set;
    next_s.intr_n = ~|(next_s.flags & ~next_s.mask & `CMX_FLAG_USED);
    next_s.busy = next_s.state != CMX_IDLE;
  end

  // One register holds the whole module state.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
      s.state <= CMX_IDLE;
      s.mask <= `CMX_RST_MASK;
      s.page <= `CMX_RST_PAGE;
      s.status <= `CMX_ST_IDLE;
      s.intr_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign lk.ack = s.ack;
  assign lk.nack = s.nack;
  assign lk.rdata = s.rdata;
  assign lk.intr_n = s.intr_n;
  assign busy = s.busy;
endmodule

// ---- hw/cmx_pkg.sv ----
// Purpose: Types shared by the module end and the host end.
// Assumes: Constants come from cmx_cfg.svh.
// Notes: Each end keeps its whole state in one packed struct.
package cmx_pkg;
  typedef enum logic [1:0] {
    CMX_IDLE = 2'b00,
    CMX_EXEC = 2'b01,
    CMX_POST = 2'b10
  } cmx_dev_state_t;

  typedef enum logic [1:0] {
    CMX_H_IDLE = 2'b00,
    CMX_H_REQ = 2'b01,
    CMX_H_WAIT = 2'b10
  } cmx_host_state_t;

  typedef struct packed {
    cmx_dev_state_t state;
    logic [7:0] page;
    logic [7:0] mask;
    logic [7:0] flags;
    logic [7:0] status;
    logic [7:0][7:0] hdr;
    logic [15:0] cnt;
    logic burst_hit;
    logic ack;
    logic nack;
    logic [7:0] rdata;
    logic intr_n;
    logic busy;
  } cmx_dev_t;

  typedef struct packed {
    cmx_host_state_t state;
    logic req;
    logic wr;
    logic stop;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic done;
    logic nacked;
    logic pready;
    logic [31:0] prdata;
  } cmx_host_t;
endpackage

// ---- hw/cmx_ram.sv ----
// Purpose: Byte array holding message bodies.
// Assumes: One write port, asynchronous read.
// Notes: Contents are undefined after reset, as payload memory is.
`timescale 1ns/1ns
module cmx_ram #(
  parameter int AW = 12
) (
  input wire logic mclk, // Clock.
  input wire logic we, // Write strobe.
  input wire logic [AW-1:0] addr, // Byte index.
  input wire logic [7:0] wdata, // Write data.
  output logic [7:0] rdata // Read data.
);
  logic [7:0] mem [0:(1<<AW)-1];

  // Writes land at the edge; reads see the array directly.
  always_ff @(posedge mclk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end
  assign rdata = mem[addr];
endmodule

// ---- tb/cmx_link_asserts.sv ----
// Purpose: Protocol checks on the link between host end and module end.
// Assumes: Background module, trigger by a single byte write.
// Notes: Sees only link signals, clock and reset.
`timescale 1ns/1ns
module cmx_link_asserts (
  input wire logic mclk, // Clock.
  input wire logic rstn, // Reset, active low.
  input wire logic req, // Request pulse.
  input wire logic wr, // Write when high.
  input wire logic [7:0] addr, // Byte address.
  input wire logic [7:0] wdata, // Write data.
  input wire logic ack, // Access served.
  input wire logic nack, // Access refused.
  input wire logic intr_n // Interrupt, active low.
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // An ordinary trigger; abort is left out since it may finish at once.
  sequence trig_s;
    req && wr && addr == 8'h81 && wdata != 8'h04 ##1 ack;
  endsequence
  answer_one_cycle_a: assert property (req |=> (ack || nack))
    else $error("link request not answered after one cycle");
  answer_exclusive_a: assert property (!(ack && nack))
    else $error("ack and nack together");
  answer_cause_a: assert property ((ack || nack) |-> $past(req))
    else $error("answer without a request");
  bg_served_a: assert property (!nack)
    else $error("background module refused an access");
  req_single_a: assert property (req |=> !req)
    else $error("request longer than one cycle");
  req_held_a: assert property (req |=> $stable(addr) && $stable(wr) && $stable(wdata))
    else $error("request fields changed before the answer");
  irq_quiet_reset_a: assert property ($rose(rstn) |-> intr_n)
    else $error("interrupt active right after reset");
  // Status goes busy first, so no completion may be flagged right after a trigger.
  flag_after_status_a: assert property (trig_s |=> (!$fell(intr_n)) [*3])
    else $error("completion flagged right after trigger");
endmodule

// ---- tb/tb.sv ----
// Purpose: Bench for host end and module end joined by the link.
// Assumes: Background module with single byte trigger, and a foreground one triggered on stop.
// Notes: Link reads are matched to queued notes by a watcher.
`timescale 1ns/1ns
`include "cmx_cfg.svh"
module tb;
  localparam int EXEC = 40;
  logic mclk = 1'h0;
  logic rstn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic pready;
  logic pslverr;
  logic busy;
  logic [31:0] prdata;
  logic sel_f = 1'h0;
  logic stp = 1'h0;
  logic pready_f;
  logic pslverr_f;
  logic busy_f;
  logic [31:0] prdata_f;
  logic [31:0] seed = 32'h6917;
  logic [31:0] st;
  logic [7:0] id;
  logic [7:0] pg [3] = '{8'h9f, 8'ha0, 8'haf};
  logic [7:0] lo [3] = '{8'h88, 8'h80, 8'h80};
  logic [7:0] exp_q [$];
  int n_mismatch = 0;
  int total_checks = 0;
  cmx_link_if lk();
  cmx_link_if lk_f();
  cmx_host i_cmx_host (.mclk(mclk), .rstn(rstn), .psel(psel && !sel_f), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .lk(lk));
  cmx_module #(.EXEC_CYCLES(EXEC)) i_cmx_module (.mclk(mclk), .rstn(rstn), .lk(lk),
    .busy(busy));
  // Second pair: foreground module, trigger on stop, no extended pages; sel_f picks the pair.
  cmx_host i_cmx_host_fg (.mclk(mclk), .rstn(rstn), .psel(psel && sel_f), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready_f), .prdata(prdata_f),
    .pslverr(pslverr_f), .lk(lk_f));
  cmx_module #(.FOREGROUND(1'h1), .TRIG_ON_STOP(1'h1), .EPL_SUPPORT(1'h0), .EXEC_CYCLES(EXEC))
    i_cmx_module_fg (.mclk(mclk), .rstn(rstn), .lk(lk_f), .busy(busy_f));
  cmx_link_asserts i_cmx_link_asserts (.mclk(mclk), .rstn(rstn), .req(lk.req), .wr(lk.wr),
    .addr(lk.addr), .wdata(lk.wdata), .ack(lk.ack), .nack(lk.nack), .intr_n(lk.intr_n));
  // Free running clock, 4 ns period.
  initial begin
    forever #2 mclk = ~mclk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic cmp8(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic give_verdict;
    if (n_mismatch == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // One APB transfer; request held until pready is seen high.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge mclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    do @(posedge mclk); while ((sel_f ? pready_f : pready) !== 1'h1);
    q = sel_f ? prdata_f : prdata;
    cmp8("slave error", 8'h00, {7'h0, sel_f ? pslverr_f : pslverr});
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // One link access; the host status is polled until it is no longer busy.
  task automatic lk_go(input logic w, input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    apb(1'h1, `CMX_APB_ADDR, {24'h0, a}, q);
    apb(1'h1, `CMX_APB_WDATA, {24'h0, d}, q);
    apb(1'h1, `CMX_APB_CTRL, {29'h0, stp, w, 1'h1}, q);
    do apb(1'h0, `CMX_APB_STAT, 32'h0, q); while (q[0] !== 1'h0);
    st = q;
    cmp8("access done", 8'h01, {7'h0, q[1]});
  endtask
  // A write that ends its burst with stop.
  task automatic wr_end(input logic [7:0] a, input logic [7:0] d);
    stp = 1'h1;
    lk_go(1'h1, a, d);
    stp = 1'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    lk_go(1'h1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    lk_go(1'h0, a, 8'h0);
    cmp8("host read", e, st[15:8]);
  endtask
  // A module that never goes idle counts as a mismatch here.
  task automatic wait_idle;
    for (int i = 0; i < 300 && (sel_f ? busy_f : busy) !== 1'h0; i++) @(posedge mclk);
    cmp8("busy clear", 8'h00, {7'h0, sel_f ? busy_f : busy});
  endtask
  // Each read answer on either link is matched against the oldest note.
  always @(posedge mclk) begin
    if (rstn && ((lk.ack === 1'h1 && lk.wr === 1'h0) ||
        (lk_f.ack === 1'h1 && lk_f.wr === 1'h0))) begin
      if (exp_q.size() > 0)
        cmp8("link read", exp_q.pop_front(), sel_f ? lk_f.rdata : lk.rdata);
      else
        cmp8("read note", 8'h01, 8'h00);
    end
  end
  // Watchdog at 20000 cycles, well beyond the thousand or so cycles the tests take.
  initial begin
    #80000;
    n_mismatch++;
    give_verdict();
  end
  initial begin
    repeat (16) @(posedge mclk);
    rstn <= 1'h1;
    wr(8'h7f, 8'h01);
    rd(8'ha3, 8'h60);
    rd(8'ha4, 8'h0f);
    rd(8'ha6, 8'h00);
    rd(8'h08, 8'h00);
    rd(8'h25, 8'h00);
    // Both ends of the local area and of the first and last extended pages.
    foreach (pg[i]) begin
      seed = xs(seed);
      wr(8'h7f, pg[i]);
      wr(lo[i], seed[7:0]);
      wr(8'hff, ~seed[7:0]);
      rd(lo[i], seed[7:0]);
      rd(8'hff, ~seed[7:0]);
    end
    // A passing command unmasked, then a failing one with completion masked.
    for (int k = 0; k < 2; k++) begin
      seed = xs(seed);
      id = seed[7:0] | 8'h10;
      wr(8'h1f, (k == 1) ? 8'h40 : 8'h00);
      wr(8'h7f, 8'h9f);
      wr(8'h80, k[7:0]);
      wr(8'h81, id);
      rd(8'h25, 8'h81);
      cmp8("busy set", 8'h01, {7'h0, busy});
      wait_idle();
      rd(8'h80, k[7:0]);
      rd(8'h81, id);
      rd(8'h25, (k == 1) ? 8'h42 : 8'h01);
      cmp8("interrupt", (k == 1) ? 8'h00 : 8'h01, {7'h0, st[3]});
      rd(8'h08, 8'h40);
      rd(8'h08, 8'h00);
      cmp8("interrupt clear", 8'h00, {7'h0, st[3]});
    end
    // Abort sent while a command runs ends it with the aborted code.
    wr(8'h80, 8'h00);
    wr(8'h81, 8'h33);
    wr(8'h81, 8'h04);
    wait_idle();
    rd(8'h25, 8'h45);
    rd(8'h08, 8'h40);
    // Foreground pair: capabilities, stop trigger, refusal while busy, abort when idle.
    sel_f <= 1'h1;
    wr(8'h7f, 8'h01);
    rd(8'ha3, 8'h40);
    rd(8'ha4, 8'h00);
    rd(8'ha6, 8'h01);
    wr(8'h7f, 8'ha0);
    wr(8'h80, 8'h5a);
    rd(8'h80, 8'h00);
    wr(8'h7f, 8'h9f);
    wr(8'h80, 8'h00);
    wr(8'h81, 8'h22);
    rd(8'h25, 8'h00);
    wr_end(8'h82, seed[15:8]);
    lk_go(1'h0, 8'h25, 8'h00);
    cmp8("refused", 8'h01, {7'h0, st[2]});
    wait_idle();
    rd(8'h25, 8'h01);
    cmp8("interrupt fg", 8'h01, {7'h0, st[3]});
    rd(8'h81, 8'h22);
    rd(8'h08, 8'h40);
    wr_end(8'h81, 8'h04);
    wait_idle();
    rd(8'h25, 8'h01);
    rd(8'h08, 8'h40);
    cmp8("notes left", 8'h00, 8'(exp_q.size()));
    repeat (4) @(posedge mclk);
    give_verdict();
  end
endmodule
